/* File: logic/lhg_gpio_port.sv */
// top: apb register file and pin drivers for the display header gpio block
// assumes board pull-ups on the control lines and an apb master on pclk
`timescale 1ns/1ps
module lhg_gpio_port (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] disp_data_in,
  output logic [7:0] disp_data_out,
  output logic [7:0] disp_data_oe,
  input wire logic disp_strobe_in,
  output logic disp_strobe_out,
  output logic disp_strobe_oe,
  input wire logic disp_reg_select_in,
  output logic disp_reg_select_out,
  output logic disp_reg_select_oe,
  input wire logic disp_write_n_in,
  output logic disp_write_n_out,
  output logic disp_write_n_oe,
  input wire logic [4:0] other_ctrl_in,
  output logic [4:0] other_ctrl_out,
  output logic [4:0] other_ctrl_oe
);
  ////////////////////////////////////////////////////////////////////////////
  function automatic lhg_pkg::lhg_reg_t decode(input logic [31:0] a);
    case (a)
      lhg_pkg::DATA_VALUE_ADDR: decode = lhg_pkg::LHG_REG_DATA_VAL;
      lhg_pkg::DATA_DIR_ADDR: decode = lhg_pkg::LHG_REG_DATA_DIR;
      lhg_pkg::CTRL_VALUE_ADDR: decode = lhg_pkg::LHG_REG_CTRL_VAL;
      lhg_pkg::CTRL_DIR_ADDR: decode = lhg_pkg::LHG_REG_CTRL_DIR;
      default: decode = lhg_pkg::LHG_REG_NONE;
    endcase
  endfunction

  // one mux for both ports: a driven bit reads its own value, an input bit the synchronised pin
  function automatic logic [7:0] pin_view(input logic [7:0] val, input logic [7:0] dir, input logic [7:0] pins);
    pin_view = (val & dir) | (pins & ~dir);
  endfunction

  lhg_pkg::lhg_reg_t sel;
  logic access;
  logic wr_en;
  logic [7:0] data_val_q;
  logic [7:0] data_dir_q;
  logic [7:0] ctrl_val_q;
  logic [7:0] ctrl_dir_q;
  logic [7:0] data_pins;
  logic [7:0] ctrl_pins;
  logic [7:0] ctrl_raw;
  logic [31:0] rdata_d;

  assign sel = decode(paddr);
  // two-cycle access phase: one wait state, pready answers in the second penable cycle
  // the !pready term stops a second store in the cycle that answers
  assign access = psel && penable && !pready;
  assign wr_en = access && pwrite;

  ////////////////////////////////////////////////////////////////////////////
  // pin inputs synchronised before any read-back
  lhg_sync2 #(.WIDTH(8)) u_data_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(disp_data_in),
    .sync_out(data_pins)
  );
  // undriven control inputs come in high through the board pull-ups
  assign ctrl_raw = {other_ctrl_in[4:3], disp_write_n_in, disp_reg_select_in, disp_strobe_in,
    other_ctrl_in[2:0]};
  lhg_sync2 #(.WIDTH(8)) u_ctrl_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(ctrl_raw),
    .sync_out(ctrl_pins)
  );

  ////////////////////////////////////////////////////////////////////////////
  // value and direction registers, all lines start as inputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_val_q <= lhg_pkg::VALUE_RESET;
      data_dir_q <= lhg_pkg::DIR_RESET;
    end else if (wr_en) begin
      if (sel == lhg_pkg::LHG_REG_DATA_VAL) data_val_q <= pwdata[7:0];
      if (sel == lhg_pkg::LHG_REG_DATA_DIR) data_dir_q <= pwdata[7:0];
    end
  end

  // whole byte written: other bits belong to other board functions
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_val_q <= lhg_pkg::VALUE_RESET;
      ctrl_dir_q <= lhg_pkg::DIR_RESET;
    end else if (wr_en) begin
      if (sel == lhg_pkg::LHG_REG_CTRL_VAL) ctrl_val_q <= pwdata[7:0];
      if (sel == lhg_pkg::LHG_REG_CTRL_DIR) ctrl_dir_q <= pwdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin read-back: outputs read the driven value, inputs read the pin
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (sel)
      lhg_pkg::LHG_REG_DATA_VAL: rdata_d[7:0] = pin_view(data_val_q, data_dir_q, data_pins);
      lhg_pkg::LHG_REG_DATA_DIR: rdata_d[7:0] = data_dir_q;
      lhg_pkg::LHG_REG_CTRL_VAL: rdata_d[7:0] = pin_view(ctrl_val_q, ctrl_dir_q, ctrl_pins);
      lhg_pkg::LHG_REG_CTRL_DIR: rdata_d[7:0] = ctrl_dir_q;
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  // unmapped address: error flagged, write dropped, read returns zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= access;
      pslverr <= access && (sel == lhg_pkg::LHG_REG_NONE);
      if (access && !pwrite) prdata <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drivers from flops; the display write sequence is software's job
  // reset leaves every line an input so nothing fights the display at power-up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disp_data_out <= lhg_pkg::VALUE_RESET;
      disp_data_oe <= lhg_pkg::DIR_RESET;
      disp_strobe_out <= lhg_pkg::VALUE_RESET[lhg_pkg::STROBE_BIT];
      disp_strobe_oe <= lhg_pkg::DIR_RESET[lhg_pkg::STROBE_BIT];
      disp_reg_select_out <= lhg_pkg::VALUE_RESET[lhg_pkg::REG_SELECT_BIT];
      disp_reg_select_oe <= lhg_pkg::DIR_RESET[lhg_pkg::REG_SELECT_BIT];
      disp_write_n_out <= lhg_pkg::VALUE_RESET[lhg_pkg::WRITE_N_BIT];
      disp_write_n_oe <= lhg_pkg::DIR_RESET[lhg_pkg::WRITE_N_BIT];
      other_ctrl_out <= {lhg_pkg::VALUE_RESET[7:6], lhg_pkg::VALUE_RESET[2:0]};
      other_ctrl_oe <= {lhg_pkg::DIR_RESET[7:6], lhg_pkg::DIR_RESET[2:0]};
    end else begin
      disp_data_out <= data_val_q;
      disp_data_oe <= data_dir_q;
      disp_strobe_out <= ctrl_val_q[lhg_pkg::STROBE_BIT];
      disp_strobe_oe <= ctrl_dir_q[lhg_pkg::STROBE_BIT];
      disp_reg_select_out <= ctrl_val_q[lhg_pkg::REG_SELECT_BIT];
      disp_reg_select_oe <= ctrl_dir_q[lhg_pkg::REG_SELECT_BIT];
      disp_write_n_out <= ctrl_val_q[lhg_pkg::WRITE_N_BIT];
      disp_write_n_oe <= ctrl_dir_q[lhg_pkg::WRITE_N_BIT];
      other_ctrl_out <= {ctrl_val_q[7:6], ctrl_val_q[2:0]};
      other_ctrl_oe <= {ctrl_dir_q[7:6], ctrl_dir_q[2:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence

  chk_apb_one_wait: assert property (@(posedge pclk) disable iff (!presetn)
    s_setup ##1 s_access |-> ##1 pready) else $error("pready not one cycle after access start");
  chk_pready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready) else $error("pready longer than one cycle");
  chk_data_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && sel == lhg_pkg::LHG_REG_DATA_VAL |-> ##2 disp_data_out == $past(pwdata[7:0], 2))
    else $error("data pins miss written value");
  chk_data_dir: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && sel == lhg_pkg::LHG_REG_DATA_DIR |-> ##2 disp_data_oe == $past(pwdata[7:0], 2))
    else $error("data direction not applied");
  chk_strobe_bit: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && sel == lhg_pkg::LHG_REG_CTRL_VAL |-> ##2 disp_strobe_out == $past(pwdata[3], 2)
    && disp_reg_select_out == $past(pwdata[4], 2) && disp_write_n_out == $past(pwdata[5], 2))
    else $error("control lines not on bits 3 to 5");
  chk_ctrl_dir: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && sel == lhg_pkg::LHG_REG_CTRL_DIR |-> ##2 disp_write_n_oe == $past(pwdata[5], 2))
    else $error("control direction not applied");
  chk_pullup_read: assert property (@(posedge pclk) disable iff (!presetn)
    access && !pwrite && sel == lhg_pkg::LHG_REG_CTRL_VAL && ctrl_dir_q[3] == 1'b0 && ctrl_pins[3]
    |=> prdata[3]) else $error("undriven control input not read as one");
  chk_other_bits: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && sel == lhg_pkg::LHG_REG_CTRL_VAL |-> ##2 other_ctrl_out == {$past(pwdata[7:6], 2), $past(pwdata[2:0], 2)})
    else $error("other control bits not kept");
  chk_bad_addr: assert property (@(posedge pclk) disable iff (!presetn)
    access && sel == lhg_pkg::LHG_REG_NONE |=> pslverr && pready) else $error("unmapped access not flagged");

  ////////////////////////////////////////////////////////////////////////////
  // pin paths: each line lands on its own bit two edges after the pin moves
  chk_ctrl_sync: assert property (@(posedge pclk) disable iff (!presetn)
    $past(presetn, 2) |-> ctrl_pins[lhg_pkg::STROBE_BIT] == $past(disp_strobe_in, 2)
    && ctrl_pins[lhg_pkg::REG_SELECT_BIT] == $past(disp_reg_select_in, 2)
    && ctrl_pins[lhg_pkg::WRITE_N_BIT] == $past(disp_write_n_in, 2))
    else $error("control pin read on wrong bit");
  chk_other_sync: assert property (@(posedge pclk) disable iff (!presetn)
    $past(presetn, 2) |-> {ctrl_pins[7:6], ctrl_pins[2:0]} == $past(other_ctrl_in, 2))
    else $error("other control pins read on wrong bits");
  chk_data_sync: assert property (@(posedge pclk) disable iff (!presetn)
    $past(presetn, 2) |-> data_pins == $past(disp_data_in, 2))
    else $error("data pins not synchronised in order");
  // strobe and select directions, then answers: read data moves only on a read and never carries upper bits
  chk_strobe_dir: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && sel == lhg_pkg::LHG_REG_CTRL_DIR |-> ##2 disp_strobe_oe == $past(pwdata[3], 2)
    && disp_reg_select_oe == $past(pwdata[4], 2)) else $error("strobe or select direction not applied");
  chk_unmapped_read: assert property (@(posedge pclk) disable iff (!presetn)
    access && !pwrite && sel == lhg_pkg::LHG_REG_NONE |=> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
    access && !pwrite |=> prdata[31:8] == 24'h00_0000) else $error("upper read bits not zero");
  chk_rdata_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !(access && !pwrite) |=> $stable(prdata)) else $error("read data moved without a read");
  chk_ready_source: assert property (@(posedge pclk) disable iff (!presetn)
    pready |-> $past(access)) else $error("pready without an access");
endmodule

/* File: logic/lhg_pkg.sv */
// package: register map and reset values for the display header gpio block
// assumes an apb slave with 32-bit data, byte addresses as printed
package lhg_pkg;
  localparam logic [31:0] DATA_VALUE_ADDR = 32'h8084_0000;
  localparam logic [31:0] DATA_DIR_ADDR = 32'h8084_0010;
  localparam logic [31:0] CTRL_VALUE_ADDR = 32'h8084_0040;
  localparam logic [31:0] CTRL_DIR_ADDR = 32'h8084_0044;
  localparam int DATA_WIDTH = 8;
  localparam int CTRL_LO_BIT = 3;
  localparam int STROBE_BIT = 3;
  localparam int REG_SELECT_BIT = 4;
  localparam int WRITE_N_BIT = 5;
  localparam int CTRL_LINES = 3;
  localparam logic [7:0] VALUE_RESET = 8'h00;
  localparam logic [7:0] DIR_RESET = 8'h00;
  localparam logic [7:0] CTRL_MASK = 8'h38;
  localparam logic [7:0] OTHER_RESET = 8'h00;
  typedef enum {LHG_REG_DATA_VAL, LHG_REG_DATA_DIR, LHG_REG_CTRL_VAL, LHG_REG_CTRL_DIR, LHG_REG_NONE} lhg_reg_t;
endpackage

/* File: logic/lhg_sync2.sv */
// two-flop synchroniser for a vector of pin inputs
// assumes pins are asynchronous to pclk
`timescale 1ns/1ps
module lhg_sync2 #(
  parameter int WIDTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  // reset to ones: matches pulled-up idle lines
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '1;
      sync_out <= '1;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

/* File: tb/lhg_disp_model.sv */
// partner: character display module seen from the header pins
// assumes the bench resolves every wire from all drivers and pull-ups
`timescale 1ns/1ps
module lhg_disp_model #(
  parameter logic [7:0] READ_BYTE = 8'h3c
) (
  input wire logic [7:0] data_bus,
  input wire logic strobe,
  input wire logic reg_select,
  input wire logic write_n,
  output logic [7:0] data_drive,
  output logic data_oe,
  output logic [7:0] last_byte,
  output logic last_rs
);
  // a read drives the bus only while strobe is high, so the host must turn its port round first
  assign data_oe = strobe & write_n;
  assign data_drive = READ_BYTE;
  // latched on the falling strobe: data changed before it is lost
  always @(negedge strobe) begin
    if (write_n == 1'b0) begin
      last_byte <= data_bus;
      last_rs <= reg_select;
    end
  end
endmodule

/* File: tb/lhg_gpio_port_bench.sv */
// bench: apb master, pin wiring with pull-ups, display model
// assumes an apb slave that answers with pready in fewer than 20 cycles of the access phase
`timescale 1ns/1ps
module lhg_gpio_port_bench;
  localparam logic [31:0] DV = lhg_pkg::DATA_VALUE_ADDR;
  localparam logic [31:0] DD = lhg_pkg::DATA_DIR_ADDR;
  localparam logic [31:0] CV = lhg_pkg::CTRL_VALUE_ADDR;
  localparam logic [31:0] CD = lhg_pkg::CTRL_DIR_ADDR;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, m_oe, l_rs;
  logic [31:0] paddr, pwdata, prdata, v, r;
  logic [7:0] d_out, d_oe, d_w, m_drv, l_byte;
  logic s_out, s_oe, rs_out, rs_oe, wn_out, wn_oe, s_w, rs_w, wn_w, e;
  logic [4:0] o_out, o_oe;
  int bad_count, total_checks;
  // undriven data lines have no bias: show the inverse so a stale value never passes
  assign d_w = (d_oe & d_out) | (~d_oe & (m_oe ? m_drv : ~d_out));
  assign s_w = s_oe ? s_out : 1'b1;
  assign rs_w = rs_oe ? rs_out : 1'b1;
  assign wn_w = wn_oe ? wn_out : 1'b1;
  lhg_gpio_port lhg_gpio_port_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .disp_data_in(d_w), .disp_data_out(d_out), .disp_data_oe(d_oe), .disp_strobe_in(s_w),
    .disp_strobe_out(s_out), .disp_strobe_oe(s_oe), .disp_reg_select_in(rs_w),
    .disp_reg_select_out(rs_out), .disp_reg_select_oe(rs_oe), .disp_write_n_in(wn_w),
    .disp_write_n_out(wn_out), .disp_write_n_oe(wn_oe), .other_ctrl_in((o_oe & o_out) | ~o_oe),
    .other_ctrl_out(o_out), .other_ctrl_oe(o_oe));
  lhg_disp_model lhg_disp_model_i (.data_bus(d_w), .strobe(s_w), .reg_select(rs_w), .write_n(wn_w),
    .data_drive(m_drv), .data_oe(m_oe), .last_byte(l_byte), .last_rs(l_rs));
  ////////////////////////////////////////////////////////////////////////////
  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (n >= 20) begin
      bad_count++;
      report_and_stop();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task t_reset;
    apb(0, CV, 0); chk(r, 32'h0000_00ff);
    apb(0, CD, 0); chk(r, 32'h0);
    apb(0, DD, 0); chk(r, 32'h0);
  endtask
  task t_pullup;
    apb(0, CV, 0); apb(1, CV, r & ~32'h38);
    apb(0, CD, 0); apb(1, CD, r | 32'h18);
    repeat (2) @(posedge pclk);
    apb(0, CV, 0); chk(r, 32'h0000_00e7);
    chk({s_w, rs_w, wn_w}, 3'b001);
    apb(0, CD, 0); apb(1, CD, r & ~32'h38);
  endtask
  task t_data;
    apb(1, DD, 32'h0000_00ff); apb(1, DV, 32'hffff_ffa5);
    @(posedge pclk); chk({d_oe, d_out}, 16'hffa5);
    apb(0, DV, 0); chk(r, 32'h0000_00a5);
  endtask
  task t_disp;
    apb(0, CD, 0); apb(1, CD, r | 32'h38); apb(1, DV, 32'h5a); apb(0, CV, 0); v = r & ~32'h38;
    apb(1, CV, v | 32'h10); apb(1, CV, v | 32'h18); apb(1, CV, v | 32'h10);
    @(posedge pclk);
    chk({l_rs, l_byte}, 9'h15a);
    chk({s_oe, rs_oe, wn_oe, o_oe}, 8'he0);
    chk(o_out, 5'h1f);
    apb(1, CV, v | 32'h38); apb(1, DD, 0);
    repeat (4) @(posedge pclk);
    apb(0, DV, 0); chk(r, 32'h0000_003c);
  endtask
  task t_unmapped;
    apb(1, DV + 4, 32'hff); chk(e, 1'b1);
    chk(d_out, 8'h5a);
    apb(0, DV + 4, 0); chk(e, 1'b1);
    chk(r, 32'h0);
  endtask
  task t_rereset;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({d_oe, d_out, s_oe, rs_oe, wn_oe, o_oe, s_out, rs_out, wn_out, o_out}, 32'h0);
    presetn <= 1'b1;
    apb(0, DD, 0); chk(r, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 0; pwdata = 0;
    bad_count = 0; total_checks = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset(); t_pullup(); t_data(); t_disp(); t_unmapped(); t_rereset();
    report_and_stop();
  end
endmodule
